// ==== hw/eeprom_spi_map.vh ====
// Constants for the serial EEPROM command front end
`ifndef EEPROM_SPI_MAP_VH
`define EEPROM_SPI_MAP_VH

// ---------------------------------------------------------------
// Opcode layout: upper nibble zero, bit 3 don't care
// ---------------------------------------------------------------
`define OPC_HI_NIB 4'h0
`define OPC_SET_WL 3'h6
`define OPC_CLR_WL 3'h4
`define OPC_RD_STAT 3'h5
`define OPC_WR_STAT 3'h1
`define OPC_RD_MEM 3'h3
`define OPC_WR_MEM 3'h2

// ---------------------------------------------------------------
// Status register field positions
// ---------------------------------------------------------------
`define SR_GPE_BIT 7
`define SR_BPHI_BIT 3
`define SR_BPLO_BIT 2
`define SR_WEL_BIT 1
`define SR_BUSY_BIT 0
`define SR_GPE_RST 1'b0
`define SR_BP_RST 2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_MHZ 10
`define WC_TIME_US 5000
`define WC_CYCLES (`WC_TIME_US * `CLK_FREQ_MHZ)

`endif

// ==== hw/eeprom_spi_front.v ====
// Slave serial front end of an SPI EEPROM, sampled on mclk_i
`timescale 1ns/1ps
`include "eeprom_spi_map.vh"

// Notes on behaviour
// - Sample on rising, shift out on falling
// - Deselected: ignore input, output high-z
// - Select starts transfer; MSb first everywhere
// - Read data starts first fall after opcode (status) or after address (memory)
// - First byte loads 8-bit instruction register
// - Decode set and clear write latch
// - Decode read and write status
// - Decode memory read and memory write
// - Bad opcode: ignore until next select
// - Pause entered only during clock low
// - Pause held while pin and select active
// - Paused: output high-z, clock and input ignored
// - Pause never stops a running write cycle
// - Deselect while paused aborts, clears latch
// - Guard pin low plus enable blocks status writes
// - Guard pin fall cancels pending status write
// - Enable bit zero: guard pin ignored
// - Status bits: enable, protect, latch, busy
// - Set latch at deselect; required before writes
// - Clear latch regardless of guard pin
// - Status write loads bits 7, 3, 2 only; also clears latch, sets busy
module eeprom_spi_front #(
  parameter [16:0] WC_CYCLES = `WC_CYCLES
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Serial pins
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_n_o,
  // Memory array side
  input wire [7:0] mem_rdata_i,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_wr_o,
  output reg mem_rd_o,
  output reg mem_commit_o,
  // Status
  output reg [7:0] status_o
);

  localparam [2:0] ST_OPC = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_SDATA = 3'h4;
  localparam [2:0] ST_IGNORE = 3'h5;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg [4:0] pin_a_ff;
  reg [4:0] pin_b_ff;
  reg sck_d_ff;
  reg cs_d_ff;
  reg wp_d_ff;
  wire cs_act = ~pin_b_ff[0];
  wire sck_s = pin_b_ff[1];
  wire si_s = pin_b_ff[2];
  wire hold_s = ~pin_b_ff[3];
  wire wp_lo = ~pin_b_ff[4];
  wire sck_rise = sck_s & ~sck_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  wire cs_fall = cs_act & ~cs_d_ff;
  wire cs_rise = ~cs_act & cs_d_ff;
  wire wp_fall = wp_lo & ~wp_d_ff;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_a_ff <= 5'h19;
      pin_b_ff <= 5'h19;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b0;
      wp_d_ff <= 1'b0;
    end else begin
      pin_a_ff <= {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
      pin_b_ff <= pin_a_ff;
      sck_d_ff <= sck_s;
      cs_d_ff <= cs_act;
      wp_d_ff <= wp_lo;
    end
  end

  // ---------------------------------------------------------------
  // Pause control
  // ---------------------------------------------------------------
  reg paused_ff;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      paused_ff <= 1'b0;
    end else if (!cs_act) begin
      paused_ff <= 1'b0;
    end else if (!sck_s) begin
      paused_ff <= hold_s;
    end
  end

  wire live = cs_act & ~paused_ff;
  wire rise_ok = live & sck_rise;
  wire fall_ok = live & sck_fall;

  // ---------------------------------------------------------------
  // Status bits and write cycle timer
  // ---------------------------------------------------------------
  reg gpe_ff;
  reg [1:0] bp_ff;
  reg wel_ff;
  reg busy_ff;
  reg [16:0] wc_cnt_ff;
  // status bit layout
  // Reserved bits read as ones during a write cycle
  wire [7:0] sr_val = {gpe_ff, {3{busy_ff}}, bp_ff, wel_ff, busy_ff};

  // ---------------------------------------------------------------
  // Serial engine
  // ---------------------------------------------------------------
  reg [2:0] state_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] in_sh_ff;
  reg [7:0] out_sh_ff;
  reg [7:0] instr_ff;
  reg addr_hi_ff;
  reg is_read_ff;
  reg load_mem_ff;
  reg set_pend_ff;
  reg clr_pend_ff;
  reg sr_got_ff;
  reg sr_cancel_ff;
  reg [7:0] sr_new_ff;
  reg mem_got_ff;
  wire [7:0] byte_in = {in_sh_ff[6:0], si_s};
  wire byte_done = rise_ok & (bit_cnt_ff == 3'h7);
  wire opc_ok = (byte_in[7:4] == `OPC_HI_NIB);
  wire [2:0] opc = byte_in[2:0];
  // Status commit allowed only with latch set and pin guard clear
  // low guard pin blocks only while the enable bit is set
  wire sr_blocked = gpe_ff & wp_lo;
  wire sr_commit = sr_got_ff & ~sr_cancel_ff & ~sr_blocked & wel_ff;
  wire mem_commit = mem_got_ff & wel_ff;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= ST_IGNORE;
      bit_cnt_ff <= 3'h0;
      in_sh_ff <= 8'h00;
      out_sh_ff <= 8'h00;
      instr_ff <= 8'h00;
      addr_hi_ff <= 1'b1;
      is_read_ff <= 1'b0;
      load_mem_ff <= 1'b0;
      set_pend_ff <= 1'b0;
      clr_pend_ff <= 1'b0;
      sr_got_ff <= 1'b0;
      sr_cancel_ff <= 1'b0;
      sr_new_ff <= 8'h00;
      mem_got_ff <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_commit_o <= 1'b0;
      gpe_ff <= `SR_GPE_RST;
      bp_ff <= `SR_BP_RST;
      wel_ff <= 1'b0;
      busy_ff <= 1'b0;
      wc_cnt_ff <= 17'h00000;
      so_o <= 1'b0;
      so_oe_n_o <= 1'b1;
      status_o <= 8'h00;
    end else begin
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_commit_o <= 1'b0;
      load_mem_ff <= 1'b0;
      status_o <= sr_val;
      if (busy_ff) begin
        if (wc_cnt_ff == 17'h00001) begin
          busy_ff <= 1'b0;
        end
        wc_cnt_ff <= wc_cnt_ff - 17'h00001;
      end
      if (load_mem_ff) begin
        out_sh_ff <= mem_rdata_i;
      end
      // Step the address once the staged byte has gone out
      if (mem_wr_o) begin
        mem_addr_o <= mem_addr_o + 16'h0001;
      end
      if (cs_fall) begin
        // each select restarts at the opcode
        state_ff <= ST_OPC;
        bit_cnt_ff <= 3'h0;
        addr_hi_ff <= 1'b1;
        set_pend_ff <= 1'b0;
        clr_pend_ff <= 1'b0;
        sr_got_ff <= 1'b0;
        sr_cancel_ff <= 1'b0;
        mem_got_ff <= 1'b0;
      end else if (cs_rise) begin
        state_ff <= ST_IGNORE;
        if (paused_ff) begin
          wel_ff <= 1'b0;
        end else if (set_pend_ff) begin
          wel_ff <= 1'b1;
        end else if (clr_pend_ff) begin
          wel_ff <= 1'b0;
        end else if (sr_commit) begin
          // enable and protect bits load; latch clears, busy sets
          gpe_ff <= sr_new_ff[`SR_GPE_BIT];
          bp_ff <= {sr_new_ff[`SR_BPHI_BIT], sr_new_ff[`SR_BPLO_BIT]};
          wel_ff <= 1'b0;
          busy_ff <= 1'b1;
          wc_cnt_ff <= WC_CYCLES;
        end else if (mem_commit) begin
          mem_commit_o <= 1'b1;
          wel_ff <= 1'b0;
          busy_ff <= 1'b1;
          wc_cnt_ff <= WC_CYCLES;
        end
      end else if (rise_ok) begin
        // capture on rising edge, MSb first
        in_sh_ff <= byte_in;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (byte_done) begin
          case (state_ff)
            ST_OPC: begin
              instr_ff <= byte_in;
              state_ff <= ST_IGNORE;
              if (opc_ok && byte_in[2:0] == `OPC_RD_STAT) begin
                // read status, data ready for next fall
                state_ff <= ST_RDATA;
                is_read_ff <= 1'b0;
                out_sh_ff <= sr_val;
              end else if (opc_ok && !busy_ff) begin
                if (opc == `OPC_SET_WL) begin
                  set_pend_ff <= 1'b1;
                end else if (opc == `OPC_CLR_WL) begin
                  clr_pend_ff <= 1'b1;
                // writes need the latch already set
                end else if (opc == `OPC_WR_STAT && wel_ff) begin
                  state_ff <= ST_SDATA;
                end else if (opc == `OPC_RD_MEM) begin
                  state_ff <= ST_ADDR;
                  is_read_ff <= 1'b1;
                end else if (opc == `OPC_WR_MEM && wel_ff) begin
                  state_ff <= ST_ADDR;
                  is_read_ff <= 1'b0;
                end
              end
            end
            ST_ADDR: begin
              addr_hi_ff <= 1'b0;
              if (addr_hi_ff) begin
                mem_addr_o[15:8] <= byte_in;
              end else begin
                mem_addr_o[7:0] <= byte_in;
                if (is_read_ff) begin
                  mem_rd_o <= 1'b1;
                  load_mem_ff <= 1'b1;
                  state_ff <= ST_RDATA;
                end else begin
                  state_ff <= ST_WDATA;
                end
              end
            end
            ST_WDATA: begin
              mem_wdata_o <= byte_in;
              mem_wr_o <= 1'b1;
              mem_got_ff <= 1'b1;
            end
            ST_SDATA: begin
              sr_new_ff <= byte_in;
              sr_got_ff <= 1'b1;
              state_ff <= ST_IGNORE;
            end
            ST_RDATA: begin
              // Reload the next byte before its first fall
              if (is_read_ff) begin
                mem_addr_o <= mem_addr_o + 16'h0001;
                mem_rd_o <= 1'b1;
                load_mem_ff <= 1'b1;
              end else begin
                out_sh_ff <= sr_val;
              end
            end
            default: begin
              state_ff <= ST_IGNORE;
            end
          endcase
        end
      end else if (fall_ok && state_ff == ST_RDATA) begin
        // shift out MSb first on falling edge
        so_o <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
      // guard pin fall cancels pending status write
      // Placed last so a fall at selection still wins
      if (cs_act && wp_fall && gpe_ff) begin
        sr_cancel_ff <= 1'b1;
      end
      so_oe_n_o <= ~(live && state_ff == ST_RDATA && !cs_rise);
    end
  end

endmodule // eeprom_spi_front

// ==== verif/mem_model.sv ====
// Memory array model facing the front end's array side
`timescale 1ns/1ps
module mem_model (
  // Clock
  input wire mclk_i,
  // Array side
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Last staged byte
  output reg [15:0] last_addr_o,
  output reg [7:0] last_data_o
);
  reg [7:0] junk_ff;
  initial begin
    junk_ff = 8'h00;
    last_addr_o = 16'h0000;
    last_data_o = 8'h00;
  end
  // Byte stands only while the fetch strobe is up; junk otherwise
  always @* begin
    rdata_o = rd_i ? (addr_i[7:0] ^ 8'h5a) : junk_ff;
  end
  always @(posedge mclk_i) begin
    junk_ff <= ~junk_ff;
    if (wr_i) begin
      last_addr_o <= addr_i;
      last_data_o <= wdata_i;
    end
  end
endmodule // mem_model

// ==== verif/eeprom_spi_front_assertions.sv ====
// Port checker for the serial EEPROM front end
`timescale 1ns/1ps
module spi_front_checker (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Watched ports
  input wire cs_n_i,
  input wire hold_n_i,
  input wire so_oe_n_o,
  input wire mem_wr_o,
  input wire mem_rd_o,
  input wire mem_commit_o,
  input wire [7:0] status_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  deselect_hiz_a: assert property (
    cs_n_i [*4] |-> so_oe_n_o) else $error("output driven while idle");
  pause_hiz_a: assert property (
    (!cs_n_i && !hold_n_i) [*8] ##1 (!cs_n_i && !hold_n_i) [*4]
    |-> so_oe_n_o) else $error("output driven while paused");
  busy_mirror_a: assert property (
    status_o[6:4] == {3{status_o[0]}}) else $error("busy copies differ");
  commit_busy_a: assert property (
    mem_commit_o |-> ##[0:3] (status_o[0] && !status_o[1]))
    else $error("write cycle not started");
  busy_refuse_a: assert property (
    status_o[0] |-> !mem_commit_o && !mem_wr_o)
    else $error("write taken while busy");
  drive_phase_a: assert property (
    !so_oe_n_o |-> !mem_wr_o) else $error("output driven in write");
  rd_wr_excl_a: assert property (
    !(mem_rd_o && mem_wr_o)) else $error("read and write together");
  status_hold_a: assert property (
    !cs_n_i [*5] |-> $stable({status_o[7], status_o[3:1]}))
    else $error("status moved while selected");
endmodule // spi_front_checker

bind eeprom_spi_front spi_front_checker chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .hold_n_i(hold_n_i),
  .so_oe_n_o(so_oe_n_o), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
  .mem_commit_o(mem_commit_o), .status_o(status_o));

// ==== verif/testbench.sv ====
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
module testbench;
  reg mclk_i = 1'h0, rst_i = 1'h1, cs_n_i = 1'h1, sck_i = 1'h0;
  reg si_i = 1'h0, hold_n_i = 1'h1, wp_n_i = 1'h1;
  reg [7:0] rx;
  integer i, n_errors = 0, n_checks = 0;
  wire so_o, so_oe_n_o, mem_wr_o, mem_rd_o, mem_commit_o;
  wire [7:0] mem_rdata_i, mem_wdata_o, status_o, lw_data;
  wire [15:0] mem_addr_o, lw_addr;
  always #50 mclk_i = ~mclk_i;
  // Short write cycle keeps the run brief
  eeprom_spi_front #(.WC_CYCLES(17'd20)) dut_u (.mclk_i(mclk_i),
    .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
    .so_oe_n_o(so_oe_n_o), .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
    .mem_commit_o(mem_commit_o), .status_o(status_o));
  mem_model mem_u (.mclk_i(mclk_i), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .wr_i(mem_wr_o), .rd_i(mem_rd_o),
    .rdata_o(mem_rdata_i), .last_addr_o(lw_addr), .last_data_o(lw_data));
  // ----------------------------------------
  // Link tasks
  // ----------------------------------------
  task tick(input integer n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task xb(input [7:0] t);
    for (i = 7; i >= 0; i = i - 1) begin
      sck_i = 1'h0;
      si_i = t[i];
      tick(4);
      sck_i = 1'h1;
      tick(4);
      rx[i] = so_o;
    end
  endtask
  task sel;
    cs_n_i = 1'h0;
    tick(4);
  endtask
  task desel;
    sck_i = 1'h0;
    tick(4);
    cs_n_i = 1'h1;
    tick(8);
  endtask
  task cmd1(input [7:0] op);
    sel;
    xb(op);
    desel;
  endtask
  task cmd_read_status(input [7:0] op, input [7:0] exp);
    sel;
    xb(op);
    xb(8'h00);
    check(rx, exp);
    desel;
  endtask
  task cmd_write_status(input [7:0] v);
    sel;
    xb(8'h01);
    xb(v);
    desel;
    tick(30);
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(6);
    rst_i = 1'h0;
    tick(4);
    check(status_o, 8'h00);
    cmd_read_status(8'h05, 8'h00);
    cmd1(8'h0e);
    cmd_read_status(8'h0d, 8'h02);
    // Mode 3: clock idles high around the frame
    sck_i = 1'h1;
    tick(4);
    sel;
    xb(8'h05);
    xb(8'h00);
    check(rx, 8'h02);
    cs_n_i = 1'h1;
    tick(8);
    sck_i = 1'h0;
    tick(4);
    cmd1(8'h04);
    cmd_read_status(8'h05, 8'h00);
    cmd_write_status(8'hff);
    cmd_read_status(8'h05, 8'h00);
    cmd1(8'h06);
    sel;
    xb(8'h02);
    xb(8'h00);
    xb(8'h12);
    xb(8'ha5);
    desel;
    tick(30);
    check(lw_addr, 16'h0012);
    check(lw_data, 8'ha5);
    sel;
    xb(8'h03);
    xb(8'h00);
    xb(8'h12);
    xb(8'h00);
    check(rx, 8'h48);
    xb(8'h00);
    check(rx, 8'h49);
    desel;
    // Pause mid read: output released, stray clocks unseen
    cmd1(8'h06);
    sel;
    xb(8'h05);
    sck_i = 1'h0;
    tick(4);
    check(so_oe_n_o, 1'h0);
    hold_n_i = 1'h0;
    tick(8);
    si_i = 1'h1;
    repeat (3) begin
      sck_i = 1'h1;
      tick(4);
      sck_i = 1'h0;
      tick(4);
    end
    check(so_oe_n_o, 1'h1);
    hold_n_i = 1'h1;
    tick(4);
    xb(8'h00);
    check(rx, 8'h02);
    desel;
    cmd1(8'h06);
    sel;
    hold_n_i = 1'h0;
    tick(8);
    cs_n_i = 1'h1;
    tick(8);
    hold_n_i = 1'h1;
    check(status_o, 8'h00);
    sel;
    xb(8'h50);
    xb(8'h06);
    xb(8'h05);
    xb(8'h00);
    check(so_oe_n_o, 1'h1);
    desel;
    check(status_o, 8'h00);
    cmd1(8'h06);
    cmd_write_status(8'hff);
    cmd_read_status(8'h05, 8'h8c);
    wp_n_i = 1'h0;
    cmd1(8'h06);
    cmd_write_status(8'h00);
    check(status_o & 8'h8d, 8'h8c);
    wp_n_i = 1'h1;
    cmd1(8'h06);
    sel;
    xb(8'h01);
    xb(8'h00);
    wp_n_i = 1'h0;
    tick(8);
    wp_n_i = 1'h1;
    desel;
    tick(30);
    check(status_o & 8'h8d, 8'h8c);
    cmd1(8'h06);
    cmd_write_status(8'h00);
    wp_n_i = 1'h0;
    cmd1(8'h06);
    cmd_write_status(8'h0c);
    check(status_o, 8'h0c);
    stop_test;
  end
  // Whole sequence needs well under 1 ms
  initial begin
    #3000000;
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule // testbench
